// File: pkg/rrt_regs.svh
/*
 * Offsets, fields, reset values and tuple constants of the reply builder.
 * Assumes one 20 MHz clock and a 4-bit word address.
 */
`ifndef RRT_REGS_SVH
`define RRT_REGS_SVH

// ============================================================
// software port
`define RRT_ADDR_W          4
`define RRT_OFF_CTRL        4'h0
`define RRT_OFF_TIMING      4'h1
`define RRT_OFF_POWER       4'h2
`define RRT_OFF_FREQ        4'h3
`define RRT_OFF_STATUS      4'h4
`define RRT_OFF_DS_FREQ     4'h5
`define RRT_OFF_US_CHAN     4'h6
`define RRT_OFF_SID_CFG     4'h7
`define RRT_OFF_EQ_CFG      4'h8
`define RRT_OFF_EQ_DATA     4'h9
`define RRT_OFF_STAT        4'hA

// ============================================================
// control fields and reset values
`define RRT_CTRL_DS_OVR     0
`define RRT_CTRL_US_OVR     1
`define RRT_CTRL_EQ_EN      2
`define RRT_CTRL_RST        3'h0
`define RRT_STATUS_RST      8'h01
`define RRT_INIT_SID_RST    14'h0000
`define RRT_TEMP_SID_RST    14'h0001
`define RRT_STAT_OVF        2

// ============================================================
// tuple types, lengths and limits
`define RRT_T_NONE          8'h00
`define RRT_T_TIMING        8'h01
`define RRT_T_POWER         8'h02
`define RRT_T_FREQ          8'h03
`define RRT_T_EQ            8'h04
`define RRT_T_STATUS        8'h05
`define RRT_T_DS_FREQ       8'h06
`define RRT_T_US_CHAN       8'h07
`define RRT_L_FOUR          3'h4
`define RRT_L_TWO           3'h2
`define RRT_L_ONE           3'h1
`define RRT_ST_CONTINUE     8'h01
`define RRT_ST_ABORT        8'h02
`define RRT_ST_SUCCESS      8'h03
`define RRT_MAX_CHUNK       10'h0FF
`define RRT_EQ_AW           10
`define RRT_MAX_TAPS        7'h40

`endif

// File: pkg/rrt_pkg.sv
/*
 * Reply builder types: query, output byte, phases, state.
 * Assumes rrt_regs.svh on the include path.
 */
package rrt_pkg;
`include "rrt_regs.svh"

    typedef struct packed {
        logic [13:0] service_identifier;           // query identifier
        logic [7:0]  chan;          // channel it arrived on
        logic        initial_slot;  // sent in an initial slot
        logic        pre_periodic;  // unicast, before periodic ranging
    } rrt_query_s;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } rrt_byte_s;

    typedef enum logic [3:0] {
        PH_IDLE, PH_SID_HI, PH_SID_LO, PH_CHAN, PH_TYPE, PH_LEN, PH_VAL,
        PH_EQ_TYPE, PH_EQ_LEN, PH_EQ_RD, PH_EQ_VAL
    } rrt_phase_e;

    typedef struct packed {
        rrt_phase_e          phase;
        logic [2:0]          ctrl;
        logic [31:0]         timing;
        logic [7:0]          power;
        logic [15:0]         freq;
        logic [7:0]          status;
        logic [31:0]         ds_freq;
        logic [7:0]          us_chan;
        logic [13:0]         init_sid;
        logic [13:0]         temp_sid;
        logic [9:0]          eq_len;
        logic [2:0]          eq_fps;
        logic [6:0]          eq_taps;
        logic                pend_v;
        rrt_query_s          pend;
        logic                ovf;
        rrt_query_s          cur;
        logic                ovr_ok;
        logic                eq_ok;
        logic [13:0]         out_sid;
        logic [7:0]          cur_type;
        logic [2:0]          idx;
        logic [9:0]          eq_addr;
        logic [9:0]          eq_rem;
        logic [7:0]          chunk;
        rrt_byte_s           tx;
        logic [31:0]         rdata;
        logic [15:0]         replies;
        logic                mem_we;
        logic [9:0]          mem_waddr;
        logic [7:0]          mem_wdata;
        logic [9:0]          mem_raddr;
    } rrt_state_s;

endpackage

// File: hdl/rrt_eq_mem.sv
/*
 * Equalizer byte memory of the next reply.
 * One write port, one registered read port.
 */
`timescale 1ns/10ps
module rrt_eq_mem
    import rrt_pkg::*;
(
    input  wire logic             clock,     // 20 MHz clock
    input  wire logic             reset_n,   // async reset, active low
    input  wire logic             we,        // write strobe
    input  wire logic [9:0]       waddr,     // write byte address
    input  wire logic [7:0]       wdata,     // write byte
    input  wire logic [9:0]       raddr,     // read byte address
    output logic      [7:0]       rdata      // read byte, one cycle after raddr
);
    logic [7:0] mem [0:(1 << `RRT_EQ_AW) - 1];

    always_ff @(posedge clock)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule // rrt_eq_mem

// File: hdl/rrt_reply_builder.sv
/*
 * Headend ranging reply builder: answers each ranging query not dropped as overflow
 * with a reply byte stream built from software-set values.
 * Assumes all inputs share the clock.
 */
// Strobed register access and the register addresses were chosen for this implementation.
// Overview of operation
// - every ranging query received is answered with one ranging reply; here a query arriving while one is pending is dropped
// - after the channel byte every parameter is a tuple
// - reply SERVICE_IDENTIFIER: init SERVICE_IDENTIFIER on move, temp SERVICE_IDENTIFIER on joining, else echo
// - type and length fields are one octet each
// - type 1 length 4: signed 32-bit timing adjust
// - type 2 length 1: signed 8-bit power change, quarter dB
// - type 3 length 2: signed 16-bit frequency change in hertz
// - type 5 length 1: status 1 continue, 2 abort, 3 success
// - optional type 6 length 4: new downstream frequency in hertz
// - optional type 7 length 1: new upstream channel identifier
// - types 8 to 255 are never emitted
// - equalizer: 1, 2 or 4 taps per symbol, at most 64 taps
// - equalizer data above 255 bytes splits over type 4 tuples
// - overrides only for joining or pre-periodic unicast queries
// - SERVICE_IDENTIFIER field is 16 bits, low 14 hold it, top two zero
`timescale 1ns/10ps
module rrt_reply_builder
    import rrt_pkg::*;
(
    input  wire logic                   clock,        // 20 MHz clock
    input  wire logic                   reset_n,      // async reset, active low
    input  wire logic [`RRT_ADDR_W-1:0] sw_addr,      // register word address
    input  wire logic [31:0]            sw_wdata,     // write data
    input  wire logic                   sw_we,        // write strobe
    input  wire logic                   sw_re,        // read strobe
    output logic      [31:0]            sw_rdata,     // read data, cycle after sw_re
    input  wire logic                   query_valid,  // one-cycle query event
    input  wire rrt_query_s             query,        // query record
    input  wire logic                   tx_ready,     // byte sink accepts
    output rrt_byte_s                   tx            // reply byte stream
);
    rrt_state_s s_q;
    rrt_state_s s_d;
    logic [7:0] eq_byte;
    logic       free;
    logic [7:0] nt;
    logic [2:0] len;
    logic [31:0] val;
    logic [2:0] sh;

    rrt_eq_mem u_mem (
        .clock   (clock),
        .reset_n (reset_n),
        .we      (s_q.mem_we),
        .waddr   (s_q.mem_waddr),
        .wdata   (s_q.mem_wdata),
        .raddr   (s_q.mem_raddr),
        .rdata   (eq_byte)
    );

    // ============================================================
    // tuple sequencing helpers
    function automatic logic [7:0] next_type(input logic [7:0] t, input rrt_state_s s);
        logic ds;
        logic us;
        ds = s.ovr_ok & s.ctrl[`RRT_CTRL_DS_OVR];
        us = s.ovr_ok & s.ctrl[`RRT_CTRL_US_OVR];
        unique case (t)
            `RRT_T_TIMING: next_type = `RRT_T_POWER;
            `RRT_T_POWER:  next_type = `RRT_T_FREQ;
            `RRT_T_FREQ:   next_type = s.eq_ok ? `RRT_T_EQ : `RRT_T_STATUS;
            `RRT_T_EQ:     next_type = `RRT_T_STATUS;
            `RRT_T_STATUS: next_type = ds ? `RRT_T_DS_FREQ : (us ? `RRT_T_US_CHAN : `RRT_T_NONE);
            `RRT_T_DS_FREQ: next_type = us ? `RRT_T_US_CHAN : `RRT_T_NONE;
            default:       next_type = `RRT_T_NONE;
        endcase
    endfunction

    always_comb
    begin
        len = `RRT_L_ONE;
        val = 32'h0000_0000;
        unique case (s_q.cur_type)
            `RRT_T_TIMING:  begin len = `RRT_L_FOUR; val = s_q.timing; end
            `RRT_T_POWER:   begin len = `RRT_L_ONE;  val = {24'h000000, s_q.power}; end
            `RRT_T_FREQ:    begin len = `RRT_L_TWO;  val = {16'h0000, s_q.freq}; end
            `RRT_T_STATUS:  begin len = `RRT_L_ONE;  val = {24'h000000, s_q.status}; end
            `RRT_T_DS_FREQ: begin len = `RRT_L_FOUR; val = s_q.ds_freq; end
            `RRT_T_US_CHAN: begin len = `RRT_L_ONE;  val = {24'h000000, s_q.us_chan}; end
            default:        begin len = `RRT_L_ONE;  val = 32'h0000_0000; end
        endcase
        sh = 3'(len - 3'h1 - s_q.idx);
        nt = next_type(s_q.cur_type, s_q);
    end

    assign free = !s_q.tx.valid || tx_ready;

    // ============================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.mem_we = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (free)
        begin
            s_d.tx.valid = 1'b0;
        end

        // software writes
        if (sw_we)
        begin
            unique case (sw_addr)
                `RRT_OFF_CTRL:    s_d.ctrl = sw_wdata[2:0];
                `RRT_OFF_TIMING:  s_d.timing = sw_wdata;
                `RRT_OFF_POWER:   s_d.power = sw_wdata[7:0];
                `RRT_OFF_FREQ:    s_d.freq = sw_wdata[15:0];
                `RRT_OFF_STATUS:  s_d.status = sw_wdata[7:0];
                `RRT_OFF_DS_FREQ: s_d.ds_freq = sw_wdata;
                `RRT_OFF_US_CHAN: s_d.us_chan = sw_wdata[7:0];
                `RRT_OFF_SID_CFG:
                begin
                    s_d.init_sid = sw_wdata[13:0];
                    s_d.temp_sid = sw_wdata[29:16];
                end
                `RRT_OFF_EQ_CFG:
                begin
                    s_d.eq_len = sw_wdata[9:0];
                    s_d.eq_fps = sw_wdata[18:16];
                    s_d.eq_taps = sw_wdata[30:24];
                end
                `RRT_OFF_EQ_DATA:
                begin
                    s_d.mem_we = 1'b1;
                    s_d.mem_wdata = sw_wdata[7:0];
                    s_d.mem_waddr = sw_wdata[25:16];
                end
                `RRT_OFF_STAT:
                begin
                    if (sw_wdata[`RRT_STAT_OVF])
                    begin
                        s_d.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // software reads
        if (sw_re)
        begin
            unique case (sw_addr)
                `RRT_OFF_CTRL:    s_d.rdata = {29'h0, s_q.ctrl};
                `RRT_OFF_TIMING:  s_d.rdata = s_q.timing;
                `RRT_OFF_POWER:   s_d.rdata = {24'h0, s_q.power};
                `RRT_OFF_FREQ:    s_d.rdata = {16'h0, s_q.freq};
                `RRT_OFF_STATUS:  s_d.rdata = {24'h0, s_q.status};
                `RRT_OFF_DS_FREQ: s_d.rdata = s_q.ds_freq;
                `RRT_OFF_US_CHAN: s_d.rdata = {24'h0, s_q.us_chan};
                `RRT_OFF_SID_CFG: s_d.rdata = {2'h0, s_q.temp_sid, 2'h0, s_q.init_sid};
                `RRT_OFF_EQ_CFG:
                    s_d.rdata = {1'b0, s_q.eq_taps, 5'h0, s_q.eq_fps, 6'h0, s_q.eq_len};
                `RRT_OFF_STAT:
                    s_d.rdata = {s_q.replies, 12'h0, !s_q.eq_ok, s_q.ovf, s_q.pend_v,
                                 s_q.phase != PH_IDLE};
                default:          s_d.rdata = 32'h0000_0000;
            endcase
        end

        // equalizer shape check
        s_d.eq_ok = s_q.ctrl[`RRT_CTRL_EQ_EN] && (s_q.eq_len != 10'h000)
                  && (s_q.eq_fps == 3'h1 || s_q.eq_fps == 3'h2 || s_q.eq_fps == 3'h4)
                  && (s_q.eq_taps != 7'h00) && (s_q.eq_taps <= `RRT_MAX_TAPS);

        // reply sequencer
        unique case (s_q.phase)
            PH_IDLE:
            begin
                if (s_q.pend_v)
                begin
                    s_d.pend_v = 1'b0;
                    s_d.cur = s_q.pend;
                    s_d.ovr_ok = (s_q.ctrl[`RRT_CTRL_DS_OVR] || s_q.ctrl[`RRT_CTRL_US_OVR])
                               && (s_q.pend.initial_slot || s_q.pend.pre_periodic);
                    if (s_d.ovr_ok)
                        s_d.out_sid = s_q.init_sid;
                    else if (s_q.pend.initial_slot && s_q.pend.service_identifier == s_q.init_sid)
                        s_d.out_sid = s_q.temp_sid;
                    else
                        s_d.out_sid = s_q.pend.service_identifier;
                    s_d.cur_type = `RRT_T_TIMING;
                    s_d.idx = 3'h0;
                    s_d.eq_addr = 10'h000;
                    s_d.eq_rem = s_q.eq_len;
                    s_d.phase = PH_SID_HI;
                end
            end
            PH_SID_HI:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b1, 1'b0, {2'b00, s_q.out_sid[13:8]}};
                    s_d.phase = PH_SID_LO;
                end
            end
            PH_SID_LO:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, s_q.out_sid[7:0]};
                    s_d.phase = PH_CHAN;
                end
            end
            PH_CHAN:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, s_q.cur.chan};
                    s_d.phase = PH_TYPE;
                end
            end
            PH_TYPE:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, s_q.cur_type};
                    s_d.phase = PH_LEN;
                end
            end
            PH_LEN:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, {5'h00, len}};
                    s_d.idx = 3'h0;
                    s_d.phase = PH_VAL;
                end
            end
            PH_VAL:
            begin
                if (free)
                begin
                    s_d.tx.valid = 1'b1;
                    s_d.tx.first = 1'b0;
                    s_d.tx.data = 8'(val >> {sh, 3'b000});
                    s_d.tx.last = (sh == 3'h0) && (nt == `RRT_T_NONE);
                    s_d.idx = 3'(s_q.idx + 3'h1);
                    if (sh == 3'h0)
                    begin
                        s_d.cur_type = nt;
                        if (nt == `RRT_T_NONE)
                        begin
                            s_d.phase = PH_IDLE;
                            s_d.replies = 16'(s_q.replies + 16'h0001);
                        end
                        else
                        begin
                            s_d.phase = (nt == `RRT_T_EQ) ? PH_EQ_TYPE : PH_TYPE;
                        end
                    end
                end
            end
            PH_EQ_TYPE:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, `RRT_T_EQ};
                    s_d.chunk = (s_q.eq_rem > `RRT_MAX_CHUNK) ? 8'hFF : s_q.eq_rem[7:0];
                    s_d.phase = PH_EQ_LEN;
                end
            end
            PH_EQ_LEN:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, s_q.chunk};
                    s_d.mem_raddr = s_q.eq_addr;
                    s_d.phase = PH_EQ_RD;
                end
            end
            PH_EQ_RD:
            begin
                s_d.phase = PH_EQ_VAL;
            end
            PH_EQ_VAL:
            begin
                if (free)
                begin
                    s_d.tx = '{1'b1, 1'b0, 1'b0, eq_byte};
                    s_d.eq_addr = 10'(s_q.eq_addr + 10'h001);
                    s_d.eq_rem = 10'(s_q.eq_rem - 10'h001);
                    s_d.chunk = 8'(s_q.chunk - 8'h01);
                    s_d.mem_raddr = 10'(s_q.eq_addr + 10'h001);
                    if (s_q.chunk == 8'h01)
                    begin
                        if (s_q.eq_rem != 10'h001)
                        begin
                            s_d.phase = PH_EQ_TYPE;
                        end
                        else
                        begin
                            s_d.cur_type = `RRT_T_STATUS;
                            s_d.phase = PH_TYPE;
                        end
                    end
                    else
                    begin
                        s_d.phase = PH_EQ_RD;
                    end
                end
            end
        endcase

        // query capture; a new query beats the slot being emptied
        if (query_valid)
        begin
            if (s_d.pend_v)
            begin
                s_d.ovf = 1'b1;
            end
            else
            begin
                s_d.pend = query;
                s_d.pend_v = 1'b1;
            end
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.phase <= PH_IDLE;
            s_q.ctrl <= `RRT_CTRL_RST;
            s_q.status <= `RRT_STATUS_RST;
            s_q.init_sid <= `RRT_INIT_SID_RST;
            s_q.temp_sid <= `RRT_TEMP_SID_RST;
            s_q.cur_type <= `RRT_T_NONE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sw_rdata = s_q.rdata;
    assign tx = s_q.tx;
endmodule // rrt_reply_builder

// File: verif/rrt_reply_props.sv
/* Port checker of the reply builder: byte holding, answer time, tuple layout.
   Assumes a bind to rrt_reply_builder. */
`timescale 1ns/10ps
module rrt_reply_props
    import rrt_pkg::*;
(
    input wire logic        clock,       // 20 MHz clock
    input wire logic        reset_n,     // async reset, active low
    input wire logic [3:0]  sw_addr,     // register word address
    input wire logic        sw_re,       // read strobe
    input wire logic [31:0] sw_rdata,    // read data
    input wire logic        query_valid, // query event
    input wire logic        tx_ready,    // sink accepts
    input wire rrt_byte_s   tx           // reply bytes
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic       acc;
    logic [7:0] cnt_q;
    logic       in_q;
    logic [1:0] oq_q;
    assign acc = tx.valid && tx_ready;
    // ==========
    // byte index, queries not begun
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            {cnt_q, in_q, oq_q} <= '0;
        else
        begin
            if (acc) cnt_q <= tx.first ? 8'h01 : cnt_q + 8'(cnt_q != 8'hFF);
            if (acc) in_q <= !tx.last;
            oq_q <= oq_q + 2'(query_valid && oq_q != 2'h3) - 2'(acc && tx.first && oq_q != 2'h0);
        end
    end
    // ==========
    // assertions
    AST_SID_TOP: assert property (tx.valid && tx.first |-> tx.data[7:6] == 2'h0)
        else $error("sid top bits");
    AST_TIM_TYPE: assert property (tx.valid && in_q && cnt_q == 8'h03 |-> tx.data == 8'h01)
        else $error("timing type");
    AST_TIM_LEN: assert property (tx.valid && in_q && cnt_q == 8'h04 |-> tx.data == 8'h04)
        else $error("timing length");
    AST_PWR: assert property (tx.valid && in_q && cnt_q == 8'h09 |-> tx.data == 8'h02)
        else $error("power type");
    AST_FRQ: assert property (tx.valid && in_q && cnt_q == 8'h0C |-> tx.data == 8'h03)
        else $error("freq type");
    AST_NEXT_TYPE: assert property (tx.valid && in_q && cnt_q == 8'h10
        |-> tx.data == 8'h04 || tx.data == 8'h05)
        else $error("type after freq");
    AST_HOLD: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx))
        else $error("byte not held");
    AST_ANSWER: assert property (query_valid && oq_q == 2'h0 && !in_q && !tx.valid
        |-> ##3 tx.valid && tx.first)
        else $error("late reply");
    AST_FIRST_CLEAN: assert property (tx.valid && tx.first |-> !in_q && !tx.last)
        else $error("nested reply");
    AST_RD_IDLE: assert property (!$past(sw_re) |-> sw_rdata == 32'h0)
        else $error("stray read data");
    AST_UNMAPPED: assert property (sw_re && sw_addr > 4'hA |=> sw_rdata == 32'h0)
        else $error("unmapped read");
    COV_LAST: cover property (acc && tx.last);
    COV_QUEUED: cover property (query_valid && oq_q != 2'h0);
    COV_STALL: cover property (tx.valid && !tx_ready);
endmodule // rrt_reply_props

// File: verif/rrt_modem_model.sv
/* Modem sink parsing each reply into its fields.
   Assumes the byte stream and clock of rrt_reply_builder. */
`timescale 1ns/10ps
module rrt_modem_model
    import rrt_pkg::*;
#(
    parameter bit         CFG_US_V = 1'h0, // config file sets upstream channel
    parameter logic [7:0] CFG_US   = 8'h00 // that channel
)
(
    input  wire logic      clock,    // 20 MHz clock
    input  wire logic      reset_n,  // async reset, active low
    input  wire logic      slow,     // stall the sink
    input  wire rrt_byte_s tx,       // reply bytes
    output logic           tx_ready  // sink accepts
);
    logic [15:0] service_identifier, pos, freq;
    logic [7:0]  chan, typ, rem, power, status, usc, b, us_next;
    logic [31:0] timing, dsf, val;
    logic [7:0]  eqb[1024];
    logic [9:0]  eqn;
    logic [3:0]  n4;
    logic [1:0]  ph, tick = 2'h0;
    logic        dsv, usv, reinit = 1'h0, tsid_ok = 1'h1;
    int          nrep = 0;
    // ==========
    // ready one cycle in four when slow
    always @(posedge clock) tick <= tick + 2'h1;
    assign tx_ready = !slow || tick == 2'h0;
    assign us_next = CFG_US_V ? CFG_US : usc;
    // ==========
    // parser, keeps its place in pos and ph between bytes
    always @(posedge clock) if (reset_n && tx.valid && tx_ready)
    begin
        b = tx.data;
        if (tx.first) {pos, ph, eqn, n4, dsv, usv} = '0;
        case (pos)
            16'h0: service_identifier[15:8] = b;
            16'h1: service_identifier[7:0] = b;
            16'h2: chan = b;
            default:
            begin
                if (ph == 2'h0) typ = b;
                n4 = n4 + 4'(ph == 2'h0 && b == 8'h04);
                if (ph == 2'h1) {rem, val} = {b, 32'h0};
                if (ph == 2'h2) {val, rem} = {val[23:0], b, rem - 8'h01};
                if (ph == 2'h2 && typ == 8'h04) eqb[eqn] = b;
                eqn = eqn + 10'(ph == 2'h2 && typ == 8'h04);
                if (ph == 2'h2 && rem == 8'h00)
                    case (typ)
                        8'h01: timing = val;
                        8'h02: power = val[7:0];
                        8'h03: freq = val[15:0];
                        8'h05: status = val[7:0];
                        8'h06: {dsv, dsf} = {1'h1, val};
                        8'h07: {usv, usc} = {1'h1, val[7:0]};
                        default: ;
                    endcase
                ph = (ph == 2'h0) ? 2'h1 : (ph == 2'h1) ? (b == 8'h00 ? 2'h0 : 2'h2)
                   : (rem == 8'h00 ? 2'h0 : 2'h2);
            end
        endcase
        pos = pos + 16'h1;
        if (tx.last) nrep = nrep + 1;
        if (tx.last) reinit = dsv || usv;
        if (tx.last && reinit) tsid_ok = 1'h0;
    end
endmodule // rrt_modem_model

// File: verif/tb.sv
/* Reply builder bench: registers, fields, overrides, equalizer, overflow.
   Assumes the modem model and the checker. */
`timescale 1ns/10ps
module tb
    import rrt_pkg::*;
;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} rrt_row_s;
    logic        clock = 1'h0, reset_n = 1'h0, sw_we = 1'h0, sw_re = 1'h0;
    logic        query_valid = 1'h0, slow = 1'h0, tx_ready;
    logic [3:0]  sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, rdv;
    rrt_query_s  query = '0;
    rrt_byte_s   tx;
    int          num_errors = 0, comparisons = 0;
    rrt_row_s    rows[11] = '{'{1'h0, 4'h0, 32'h0}, '{1'h0, 4'h4, 32'h1},
        '{1'h0, 4'h7, 32'h00010000}, '{1'h1, 4'h1, 32'h80000001}, '{1'h1, 4'h2, 32'hFE},
        '{1'h1, 4'h3, 32'h8001}, '{1'h1, 4'h4, 32'h3}, '{1'h1, 4'h5, 32'h12345678},
        '{1'h1, 4'h6, 32'h5}, '{1'h1, 4'h7, 32'h00420010}, '{1'h1, 4'hF, 32'hFFFFFFFF}};
    rrt_reply_builder i_dut (.clock(clock), .reset_n(reset_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata),
        .query_valid(query_valid), .query(query), .tx_ready(tx_ready), .tx(tx));
    rrt_modem_model i_modem (.clock(clock), .reset_n(reset_n), .slow(slow), .tx(tx),
        .tx_ready(tx_ready));
    initial forever #25 clock = ~clock;
    // ==========
    // bus, query and check tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) num_errors++;
        if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock) {sw_we, sw_addr, sw_wdata} <= {1'h1, a, d};
        @(posedge clock) sw_we <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock) {sw_re, sw_addr} <= {1'h1, a};
        @(posedge clock) sw_re <= 1'h0;
        #1 rdv = sw_rdata;
    endtask
    task automatic qry(input logic [13:0] s, input logic [7:0] c, input logic i, input logic p);
        @(posedge clock) {query_valid, query} <= {1'h1, s, c, i, p};
        @(posedge clock) query_valid <= 1'h0;
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_rep(input int n);
        for (int i = 0; i < 20000 && i_modem.nrep < n; i++)
            @(posedge clock) #1;
        if (i_modem.nrep < n) num_errors++;
        if (i_modem.nrep < n) tally_and_finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        foreach (rows[i])
        begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("register", rdv, (rows[i].a == 4'hF) ? 32'h0 : rows[i].d);
        end
        slow <= 1'h1;
        qry(14'h0010, 8'h03, 1'h1, 1'h0);
        wait_rep(1);
        chk("sid", i_modem.service_identifier, 32'h42);
        chk("chan", i_modem.chan, 32'h03);
        chk("timing", i_modem.timing, 32'h80000001);
        chk("power", i_modem.power, 32'hFE);
        chk("freq", i_modem.freq, 32'h8001);
        chk("status", i_modem.status, 32'h3);
        slow <= 1'h0;
        qry(14'h0123, 8'h07, 1'h0, 1'h0);
        wait_rep(2);
        chk("echo sid", i_modem.service_identifier, 32'h0123);
        wr(4'h0, 32'h3);
        qry(14'h0055, 8'h01, 1'h1, 1'h0);
        wait_rep(3);
        chk("move sid", i_modem.service_identifier, 32'h10);
        chk("ds freq", i_modem.dsf, 32'h12345678);
        chk("us chan", i_modem.usc, 32'h5);
        chk("us next", i_modem.us_next, 32'h5);
        chk("tsid", i_modem.tsid_ok, 32'h0);
        chk("moved", i_modem.reinit, 32'h1);
        qry(14'h0055, 8'h01, 1'h0, 1'h0);
        wait_rep(4);
        chk("no move", i_modem.reinit, 32'h0);
        wr(4'h0, 32'h4);
        wr(4'h8, 32'h4002012C);
        for (int i = 0; i < 300; i++) wr(4'h9, {6'h00, 10'(i), 8'h00, 8'(i) ^ 8'h5A});
        slow <= 1'h1;
        qry(14'h0200, 8'h02, 1'h0, 1'h1);
        wait_rep(5);
        chk("eq count", i_modem.eqn, 32'd300);
        chk("eq tuples", i_modem.n4, 32'h2);
        for (int i = 0; i < 300; i++) chk("eq byte", i_modem.eqb[i], 8'(i) ^ 8'h5A);
        wr(4'h8, 32'h4003012C);
        qry(14'h0200, 8'h02, 1'h0, 1'h1);
        wait_rep(6);
        chk("eq refused", i_modem.eqn, 32'h0);
        @(posedge clock) query_valid <= 1'h1;
        repeat (3) @(posedge clock);
        query_valid <= 1'h0;
        wait_rep(8);
        rd(4'hA);
        chk("overflow", rdv[2], 32'h1);
        chk("replies", rdv[31:16], 32'h8);
        wr(4'hA, 32'h4);
        rd(4'hA);
        chk("overflow cleared", rdv[2], 32'h0);
        tally_and_finish;
    end
endmodule // tb
bind rrt_reply_builder rrt_reply_props i_props (.clock(clock), .reset_n(reset_n),
    .sw_addr(sw_addr), .sw_re(sw_re), .sw_rdata(sw_rdata), .query_valid(query_valid),
    .tx_ready(tx_ready), .tx(tx));
